//--- rtl/mpsad_params.svh
// Opcode, field positions and reset values for the multiply/add datapath
`ifndef MPSAD_PARAMS_SVH
`define MPSAD_PARAMS_SVH
`define MPSAD_OP_MSB        31
`define MPSAD_OP_LSB        26
`define MPSAD_SRCA_MSB      25
`define MPSAD_SRCA_LSB      21
`define MPSAD_SRCB_MSB      20
`define MPSAD_SRCB_LSB      16
`define MPSAD_DST_MSB       15
`define MPSAD_DST_LSB       11
`define MPSAD_SHAMT_MSB     10
`define MPSAD_SHAMT_LSB     6
`define MPSAD_FN_MSB        5
`define MPSAD_FN_LSB        0
`define MPSAD_OP_SPECIAL    6'h00
`define MPSAD_OP_SPECIAL2   6'h1c
`define MPSAD_FN_SUM_TRAP   6'h20
`define MPSAD_FN_SUM_NOTRAP 6'h21
`define MPSAD_FN_SHIFT      6'h00
`define MPSAD_FN_DEDUCT     6'h05
`define MPSAD_FN_LOWPROD    6'h02
`define MPSAD_SA_INHIBIT    5'h01
`define MPSAD_ZERO15        15'h0000
`define MPSAD_ZERO32       32'h0000_0000
`define MPSAD_ZERO64       64'h0000_0000_0000_0000
`define MPSAD_ZERO5        5'h00
`endif

//--- rtl/mpsad_pkg.sv
// Types shared by the multiply/add datapath
package mpsad_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_NOOP,
    OP_SUM_TRAP,
    OP_SUM_NOTRAP,
    OP_DEDUCT,
    OP_LOWPROD
  } mpsad_op_e;
endpackage : mpsad_pkg

//--- rtl/mpsad_datapath.sv
// Integer execution datapath: multiply-subtract, multiply, no-op, add
// Summary of operation
// [RULE_01] Multiply-subtract forms full 64-bit unsigned product of both sources.
// [RULE_02] Product subtracted from upper:bottom accumulator pair, written back.
// [RULE_03] Multiply-subtract and multiply-to-register never raise exceptions.
// [RULE_04] Multiply-to-register: signed 64-bit product, low 32 bits to dest.
// [RULE_05] Accumulator halves undefined after multiply-to-register; left unchanged.
// [RULE_06] Superscalar-inhibit no-op behaves as an ordinary no-op.
// [RULE_07] Add decoded from opcode 000000, function 100000, three 5-bit fields.
// [RULE_08] Issuer keeps unnamed zero fields at zero; else unpredictable.
// [RULE_09] Signed add overflow: destination untouched, overflow exception raised.
// [RULE_10] Signed add without overflow writes 32-bit sum to destination.
// [RULE_11] Issuer keeps branches, returns, wait out of delay slots.
// [RULE_12] Sum without trap: same sum, never traps, always writes.
// [RULE_13] Overflow when bit 32 of 33-bit sign-extended sum differs from bit 31.
// [RULE_14] Accumulator update wraps modulo 2^64, borrow discarded.
`include "mpsad_params.svh"
`timescale 1ns/1ns
`default_nettype none
module mpsad_datapath (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] source_a_val_i,
  input  wire logic [31:0] source_b_val_i,
  output logic [4:0]       source_a_field_o,
  output logic [4:0]       source_b_field_o,
  output logic             wr_en_o,
  output logic [4:0]       wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic             ovf_exc_o,
  output logic             illegal_o,
  output logic [31:0]      product_upper_half_o,
  output logic [31:0]      product_bottom_half_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode
  mpsad_pkg::mpsad_op_e op;
  logic [5:0]  opc;
  logic [5:0]  fn;
  logic [4:0]  sa;
  logic [4:0]  rd;
  logic        noop_fields_clear;
  assign opc = instr_i[`MPSAD_OP_MSB:`MPSAD_OP_LSB];
  assign fn  = instr_i[`MPSAD_FN_MSB:`MPSAD_FN_LSB];
  assign sa  = instr_i[`MPSAD_SHAMT_MSB:`MPSAD_SHAMT_LSB];
  assign rd  = instr_i[`MPSAD_DST_MSB:`MPSAD_DST_LSB];
  // Register file reads are combinational on the field outputs
  assign source_a_field_o = instr_i[`MPSAD_SRCA_MSB:`MPSAD_SRCA_LSB];
  assign source_b_field_o = instr_i[`MPSAD_SRCB_MSB:`MPSAD_SRCB_LSB];
  // Both no-op forms need every register field clear
  assign noop_fields_clear =
    instr_i[`MPSAD_SRCA_MSB:`MPSAD_DST_LSB] == `MPSAD_ZERO15;

  // Nonzero unused fields are screened only for the no-op forms; issuer keeps them zero
  // Trade-off: a full screen would add a wide compare to every opcode
  always_comb begin
    op = mpsad_pkg::OP_NONE;
    if (opc == `MPSAD_OP_SPECIAL) begin
      if (fn == `MPSAD_FN_SUM_TRAP) begin
        op = mpsad_pkg::OP_SUM_TRAP; // RULE_07
      end else if (fn == `MPSAD_FN_SUM_NOTRAP) begin
        op = mpsad_pkg::OP_SUM_NOTRAP; // RULE_12
      end else if (fn == `MPSAD_FN_SHIFT && noop_fields_clear &&
                   (sa == `MPSAD_ZERO5 || sa == `MPSAD_SA_INHIBIT)) begin
        // Inhibit form only orders issue slots; here it is a plain no-op
        op = mpsad_pkg::OP_NOOP; // RULE_06
      end
    end else if (opc == `MPSAD_OP_SPECIAL2) begin
      if (fn == `MPSAD_FN_DEDUCT) begin
        op = mpsad_pkg::OP_DEDUCT; // RULE_01
      end else if (fn == `MPSAD_FN_LOWPROD) begin
        op = mpsad_pkg::OP_LOWPROD; // RULE_04
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic
  logic [32:0] sum33;
  logic        ovf;
  logic [63:0] uprod;
  logic [63:0] sprod;
  logic [63:0] acc_q;
  logic [63:0] acc_new;
  assign sum33 = {source_a_val_i[31], source_a_val_i} +
                 {source_b_val_i[31], source_b_val_i}; // RULE_13
  assign ovf   = sum33[32] != sum33[31]; // RULE_13
  assign uprod = {`MPSAD_ZERO32, source_a_val_i} *
                 {`MPSAD_ZERO32, source_b_val_i}; // RULE_01
  // Operands widened first so the product is the full signed 64 bits
  assign sprod = {{32{source_a_val_i[31]}}, source_a_val_i} *
                 {{32{source_b_val_i[31]}}, source_b_val_i}; // RULE_04
  assign acc_new = acc_q - uprod; // RULE_02 RULE_14

  ////////////////////////////////////////////////////////////////////////////
  // Result and accumulator state
  logic        wr_en_q,  wr_en_d;
  logic [4:0]  wr_addr_q, wr_addr_d;
  logic [31:0] wr_data_q, wr_data_d;
  logic        ovf_q,    ovf_d;
  logic        ill_q,    ill_d;
  logic [63:0] acc_d;

  always_comb begin
    wr_en_d   = 1'b0;
    wr_addr_d = rd;
    wr_data_d = `MPSAD_ZERO32;
    ovf_d     = 1'b0;
    ill_d     = 1'b0;
    acc_d     = acc_q;
    if (issue_valid_i) begin
      unique case (op)
        mpsad_pkg::OP_NONE: begin
          ill_d = 1'b1;
        end
        mpsad_pkg::OP_NOOP: begin
        end
        mpsad_pkg::OP_SUM_TRAP: begin
          if (ovf) begin
            ovf_d = 1'b1; // RULE_09
          end else begin
            wr_en_d   = 1'b1; // RULE_10
            wr_data_d = sum33[31:0];
          end
        end
        mpsad_pkg::OP_SUM_NOTRAP: begin
          wr_en_d   = 1'b1; // RULE_12
          wr_data_d = sum33[31:0];
        end
        mpsad_pkg::OP_DEDUCT: begin
          acc_d = acc_new; // RULE_02 RULE_03
        end
        mpsad_pkg::OP_LOWPROD: begin
          // Accumulator is architecturally undefined; keep it to save power
          wr_en_d   = 1'b1; // RULE_04 RULE_05 RULE_03
          wr_data_d = sprod[31:0];
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_en_q   <= 1'b0;
      wr_addr_q <= `MPSAD_ZERO5;
      wr_data_q <= `MPSAD_ZERO32;
      ovf_q     <= 1'b0;
      ill_q     <= 1'b0;
      acc_q     <= `MPSAD_ZERO64;
    end else begin
      wr_en_q   <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      ovf_q     <= ovf_d;
      ill_q     <= ill_d;
      acc_q     <= acc_d;
    end
  end

  assign wr_en_o               = wr_en_q;
  assign wr_addr_o             = wr_addr_q;
  assign wr_data_o             = wr_data_q;
  assign ovf_exc_o             = ovf_q;
  assign illegal_o             = ill_q;
  assign product_upper_half_o  = acc_q[63:32];
  assign product_bottom_half_o = acc_q[31:0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Checks: multiply forms

  a_deduct_acc_update: assert property ( // RULE_02
    issue_valid_i && op == mpsad_pkg::OP_DEDUCT |=>
      {product_upper_half_o, product_bottom_half_o} ==
      $past(acc_q) - {`MPSAD_ZERO32, $past(source_a_val_i)} *
                     {`MPSAD_ZERO32, $past(source_b_val_i)})
    else $error("accumulator not reduced by unsigned product");

  a_product_no_exc: assert property ( // RULE_03
    issue_valid_i &&
      (op == mpsad_pkg::OP_DEDUCT || op == mpsad_pkg::OP_LOWPROD)
      |=> !ovf_exc_o)
    else $error("multiply raised an exception");

  a_deduct_no_write: assert property ( // RULE_01
    issue_valid_i && op == mpsad_pkg::OP_DEDUCT |=> !wr_en_o)
    else $error("multiply-subtract wrote a general register");

  a_deduct_no_illegal: assert property ( // RULE_03
    issue_valid_i && op == mpsad_pkg::OP_DEDUCT |=> !illegal_o)
    else $error("multiply-subtract flagged as unknown");

  // Product above the old value must wrap round, never saturate
  a_deduct_wrap: assert property ( // RULE_14
    issue_valid_i && op == mpsad_pkg::OP_DEDUCT &&
      ({`MPSAD_ZERO32, source_a_val_i} *
       {`MPSAD_ZERO32, source_b_val_i}) > acc_q |=>
      {product_upper_half_o, product_bottom_half_o} > $past(acc_q))
    else $error("accumulator borrow not discarded");

  a_lowprod_low_word: assert property ( // RULE_04
    issue_valid_i && op == mpsad_pkg::OP_LOWPROD |=> wr_en_o &&
      wr_data_o == 32'($signed($past(source_a_val_i)) *
                       $signed($past(source_b_val_i))))
    else $error("multiply low word wrong");

  a_lowprod_addr: assert property ( // RULE_04
    issue_valid_i && op == mpsad_pkg::OP_LOWPROD |=>
      wr_addr_o == $past(rd))
    else $error("multiply wrote the wrong register");

  a_lowprod_acc_keep: assert property ( // RULE_05
    issue_valid_i && op == mpsad_pkg::OP_LOWPROD |=> $stable(acc_q))
    else $error("multiply to register moved the accumulator");

  a_acc_hold: assert property ( // RULE_14
    !(issue_valid_i && op == mpsad_pkg::OP_DEDUCT) |=> $stable(acc_q))
    else $error("accumulator changed without multiply-subtract");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: add forms

  a_add_decode: assert property ( // RULE_07
    issue_valid_i && opc == `MPSAD_OP_SPECIAL &&
      fn == `MPSAD_FN_SUM_TRAP |=> wr_en_o ^ ovf_exc_o)
    else $error("trapping add not decoded");

  a_add_no_illegal: assert property ( // RULE_07
    issue_valid_i && op == mpsad_pkg::OP_SUM_TRAP |=> !illegal_o)
    else $error("trapping add flagged as unknown");

  a_add_ovf_trap: assert property ( // RULE_09
    issue_valid_i && op == mpsad_pkg::OP_SUM_TRAP &&
      (source_a_val_i[31] == source_b_val_i[31]) &&
      (sum33[31] != source_a_val_i[31]) |=> ovf_exc_o && !wr_en_o)
    else $error("overflow did not trap");

  // Same-sign operands with a sum of the other sign is the only overflow
  a_ovf_detect: assert property ( // RULE_13
    issue_valid_i && op == mpsad_pkg::OP_SUM_TRAP |=>
      ovf_exc_o == (($past(source_a_val_i[31]) ==
                     $past(source_b_val_i[31])) &&
                    ($past(source_a_val_i[31]) !=
                     $past(wr_data_d[31] | sum33[31]))))
    else $error("overflow flag does not follow operand signs");

  a_ovf_only_trap: assert property ( // RULE_09
    !(issue_valid_i && op == mpsad_pkg::OP_SUM_TRAP) |=> !ovf_exc_o)
    else $error("overflow raised by another operation");

  a_add_sum_write: assert property ( // RULE_10
    issue_valid_i && op == mpsad_pkg::OP_SUM_TRAP && !ovf |=>
      wr_en_o && wr_data_o == $past(source_a_val_i) + $past(source_b_val_i))
    else $error("add result wrong");

  a_add_dest_addr: assert property ( // RULE_10
    issue_valid_i && op == mpsad_pkg::OP_SUM_TRAP && !ovf |=>
      wr_addr_o == $past(rd))
    else $error("add wrote the wrong register");

  a_sum_notrap_write: assert property ( // RULE_12
    issue_valid_i && op == mpsad_pkg::OP_SUM_NOTRAP |=> wr_en_o &&
      !ovf_exc_o && wr_addr_o == $past(rd))
    else $error("non-trapping add misbehaved");

  a_notrap_sum: assert property ( // RULE_12
    issue_valid_i && op == mpsad_pkg::OP_SUM_NOTRAP |=>
      wr_data_o == $past(source_a_val_i) + $past(source_b_val_i))
    else $error("non-trapping add result wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: no-op, unknown words and idle cycles

  a_noop_quiet: assert property ( // RULE_06
    issue_valid_i && op == mpsad_pkg::OP_NOOP |=>
      !wr_en_o && !ovf_exc_o && $stable(acc_q))
    else $error("no-op changed state");

  a_noop_no_illegal: assert property ( // RULE_06
    issue_valid_i && op == mpsad_pkg::OP_NOOP |=> !illegal_o)
    else $error("no-op flagged as unknown");

  a_unknown_illegal: assert property ( // RULE_07
    issue_valid_i && op == mpsad_pkg::OP_NONE |=> illegal_o && !wr_en_o)
    else $error("unknown word not flagged");

  a_idle_no_strobe: assert property ( // RULE_06
    !issue_valid_i |=> !wr_en_o && !ovf_exc_o && !illegal_o)
    else $error("strobe without an issued word");

  a_strobe_exclusive: assert property ( // RULE_09
    wr_en_o |-> !ovf_exc_o && !illegal_o)
    else $error("write and exception in one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Coverage of the main scenarios

  c_deduct: cover property (issue_valid_i && op == mpsad_pkg::OP_DEDUCT);
  c_lowprod: cover property (issue_valid_i && op == mpsad_pkg::OP_LOWPROD);
  c_ovf: cover property (ovf_exc_o);
  c_sum_without_trap_wrap: cover property (issue_valid_i &&
    op == mpsad_pkg::OP_SUM_NOTRAP && ovf);
  c_inhibit_noop: cover property (issue_valid_i &&
    op == mpsad_pkg::OP_NOOP && sa == `MPSAD_SA_INHIBIT);
endmodule : mpsad_datapath
`default_nettype wire

//--- bench/mpsad_regfile_model.sv
// Register file model on the far side of the datapath
`timescale 1ns/1ns
`default_nettype none
module mpsad_regfile_model (
  input  wire logic        mclk_i,
  input  wire logic [4:0]  rd_a_i,
  input  wire logic [4:0]  rd_b_i,
  input  wire logic        wr_en_i,
  input  wire logic [4:0]  wr_addr_i,
  input  wire logic [31:0] wr_data_i,
  output logic [31:0]      rd_a_o,
  output logic [31:0]      rd_b_o
);
  // Bench preloads operands here; same-cycle read, as the pipeline does
  logic [31:0] regs [32];
  assign rd_a_o = regs[rd_a_i];
  assign rd_b_o = regs[rd_b_i];
  always @(posedge mclk_i) begin
    if (wr_en_i) regs[wr_addr_i] <= wr_data_i;
  end
endmodule : mpsad_regfile_model
`default_nettype wire

//--- bench/mpsad_datapath_tb.sv
// Self-checking bench for the multiply/add datapath
`timescale 1ns/1ns
`default_nettype none
module mpsad_datapath_tb;
  typedef struct {
    logic wr, ovf, ill, acc_ok;
    logic [31:0] data;
    logic [63:0] acc;
  } mpsad_note_s;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        issue_valid_i = 1'b0;
  logic [31:0] instr_i = 32'h0000_0000;
  logic [4:0]  fa, fb, wr_addr;
  logic        wr_en, ovf_exc, illegal;
  logic [31:0] va, vb, wr_data, upper, bottom;
  logic [31:0] seed = 32'h0000_ff7b;
  logic [63:0] acc = 64'h0000_0000_0000_0000;
  mpsad_note_s notes [$];
  int          err_count = 0;
  int          cmp_count = 0;

  always #2 mclk_i = ~mclk_i;

  mpsad_datapath i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .issue_valid_i(issue_valid_i), .instr_i(instr_i),
    .source_a_val_i(va), .source_b_val_i(vb),
    .source_a_field_o(fa), .source_b_field_o(fb), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .ovf_exc_o(ovf_exc),
    .illegal_o(illegal), .product_upper_half_o(upper),
    .product_bottom_half_o(bottom));
  mpsad_regfile_model i_rf (.mclk_i(mclk_i), .rd_a_i(fa), .rd_b_i(fb),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .rd_a_o(va), .rd_b_o(vb));

  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish();
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Kinds: 0 add, 1 add no trap, 2 mult-sub, 3 shift nop, 4 inhibit nop,
  // 5 unknown, 6 mult to reg (last: it leaves the pair undefined)
  task issue(input int k, input logic [31:0] a, input logic [31:0] b);
    mpsad_note_s n;
    logic [32:0] s;
    logic [63:0] p;
    logic [31:0] w;
    s = {a[31], a} + {b[31], b};
    p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
    n = '{1'b0, 1'b0, 1'b0, 1'b1, s[31:0], acc};
    // Unused fields kept zero, no control transfer ever issued
    w = 32'h0022_1800;
    case (k)
      0: begin w[5:0] = 6'h20; n.ovf = s[32] ^ s[31]; n.wr = ~n.ovf; end
      1: begin w[5:0] = 6'h21; n.wr = 1'b1; end
      2: begin
        w = 32'h7022_0005;
        acc = acc - {32'h0000_0000, a} * {32'h0000_0000, b};
        n.acc = acc;
      end
      3: w = 32'h0000_0000;
      4: w = 32'h0000_0040;
      5: begin w = 32'hfc00_0000; n.ill = 1'b1; end
      default: begin
        w[31:26] = 6'h1c; w[5:0] = 6'h02;
        n.wr = 1'b1; n.data = p[31:0]; n.acc_ok = 1'b0;
      end
    endcase
    i_rf.regs[1] = a;
    i_rf.regs[2] = b;
    instr_i = w;
    issue_valid_i = 1'b1;
    notes.push_back(n);
    @(posedge mclk_i);
    #1;
  endtask : issue

  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin : watch
    mpsad_note_s n;
    logic chk;
    // Result is registered on the very edge that takes the word
    chk = issue_valid_i & ~sys_rst_i;
    #1;
    if (chk) begin
      n = notes.pop_front();
      check(64'(wr_en), 64'(n.wr));
      check(64'(ovf_exc), 64'(n.ovf));
      check(64'(illegal), 64'(n.ill));
      if (n.wr) check(64'(wr_data), 64'(n.data));
      if (n.wr) check(64'(wr_addr), 64'h3);
      if (n.acc_ok) check({upper, bottom}, n.acc);
    end
  end

  task do_reset();
    sys_rst_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    check({upper, bottom}, 64'h0);
    acc = 64'h0;
  endtask : do_reset

  initial begin
    do_reset();
    issue(2, 32'hffff_ffff, 32'hffff_ffff);
    issue(0, 32'h7fff_ffff, 32'h0000_0001);
    issue(0, 32'h8000_0000, 32'hffff_ffff);
    issue(0, 32'h7fff_ffff, 32'h8000_0000);
    issue(1, 32'h7fff_ffff, 32'h0000_0001);
    for (int k = 0; k < 7; k++) begin
      for (int j = 0; j < 8; j++) issue(k, rnd(), rnd());
    end
    issue_valid_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    // Second reset in mid-run must clear the pair again
    #1;
    do_reset();
    issue(2, 32'h0000_0002, 32'h0000_0003);
    issue_valid_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    check(64'(notes.size()), 64'h0);
    tally_and_finish();
  end
endmodule : mpsad_datapath_tb
`default_nettype wire
